// ---- rtl/cmd_regs_pkg.sv ----
/*
 command register bank constants: selector offsets, field positions, widths,
 reset values and timing counts.
 assumes a single 25 MHz clock shared with the frame decoder.
*/
// Contract
// - status bit 3 follows the over-temperature report, set high, clear when ok.
// - command arriving while another executes is rejected and sets status bit 2.
// - unrecognised command code sets status bit 1, valid command keeps it low.
// - frame checksum error sets status bit 0, a valid frame clears it.
// - second status bit 1 set on chain end, cleared by readout start.
// - second status bit 0 set on memory saturation, cleared by acquisition start.
// - info request bits 6..0 each ask for one fixed word, self-clear on done; the code has words for bits 5..0 only, bit 6 selects none.
// - board information words are firmware constants the host cannot change.
// - readback bit 0 starts config upload, cleared when the transfer finishes.
// - readback bits 8..1 show the header of the latest first data word.
// - download bit 0 starts firmware download, cleared by the device when done.
// - download bit 1 reads one when last downstream checksum passed.
// - selector reset bit holds selection logic in reset four cycles, then clears.
// - source bit 0 picks board-to-board input when one, concentrator when zero.
// - prewarning bit 0 moves into active mode, self-clears on completion.
// - dump bit 0 returns all registers in one transfer, lowest address first.
// - fast-order bit 0 derives a fast command from the frame, debug only.
// - completion shows done, beam window active and mirrors the busy output.
// - five-bit field counts triggers during the beam window.
// - arm command clears the whole completion register; the code clears done and the count, the busy bit keeps mirroring hw_busy_in.
// - after arm, measurement starts only on the external beam-window signal.
// - selector decode: commands 0x0000-0x0090, partitions two 4K sets each from 0x1000.
// - first status word is read-only and reads zero after reset.
package cmd_regs_pkg;
	localparam int unsigned SEL_W = 16;
	localparam int unsigned DATA_W = 16;
	// ============================================================
	// selector offsets
	localparam logic [15:0] OFS_INFO = 16'h0014;
	localparam logic [15:0] OFS_READBACK = 16'h0016;
	localparam logic [15:0] OFS_FW_DL = 16'h0018;
	localparam logic [15:0] OFS_SRC_SEL = 16'h001a;
	localparam logic [15:0] OFS_PREWARN = 16'h001c;
	localparam logic [15:0] OFS_DUMP = 16'h001e;
	localparam logic [15:0] OFS_FAST = 16'h0020;
	localparam logic [15:0] OFS_COMPLETION = 16'h0084;
	localparam logic [15:0] OFS_ARM = 16'h0086;
	localparam logic [15:0] CMD_LAST = 16'h0090;
	localparam logic [15:0] SC_FIRST = 16'h1000;
	localparam logic [15:0] SC_LAST = 16'h8fff;
	// ============================================================
	// field positions
	localparam int unsigned INFO_BITS = 7;
	localparam int unsigned HDR_LSB = 1;
	localparam int unsigned HDR_W = 8;
	localparam int unsigned DL_CRC_BIT = 1;
	localparam int unsigned SELRST_BIT = 1;
	localparam int unsigned HIT_W = 5;
	localparam int unsigned CMP_DONE_BIT = 0;
	localparam int unsigned CMP_SPILL_BIT = 1;
	localparam int unsigned CMP_BUSY_BIT = 2;
	localparam int unsigned CMP_HIT_LSB = 3;
	localparam int unsigned ST_TEMP = 3;
	localparam int unsigned ST_REJ = 2;
	localparam int unsigned ST_UNK = 1;
	localparam int unsigned ST_CRC = 0;
	localparam int unsigned SEC_END = 1;
	localparam int unsigned SEC_SAT = 0;
	localparam logic [15:0] ZERO16 = 16'h0000;
	// ============================================================
	// timing
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned SELRST_CYCLES = 4;
	localparam logic [2:0] SELRST_CNT = 3'(SELRST_CYCLES);
	// board information words: values arbitrary
	localparam logic [15:0] INFO_SERIAL = 16'h0001;
	localparam logic [15:0] INFO_BOARD_REV = 16'h0002;
	localparam logic [15:0] INFO_BOARD_NUM = 16'h0003;
	localparam logic [15:0] INFO_PROD_DAY = 16'h0004;
	localparam logic [15:0] INFO_FW_REV = 16'h0005;
	localparam logic [15:0] INFO_FW_DAY = 16'h0006;
	typedef enum logic [2:0]
	{
		ARM_IDLE = 3'h1,
		ARM_WAIT = 3'h2,
		ARM_MEAS = 3'h4
	} arm_state_t;
endpackage

// ---- rtl/cmd_regs.sv ----
/*
 command and status register bank of the detector interface board.
 assumes the frame decoder presents one selector/argument strobe per frame and
 reports checksum and command validity in the same cycle; engines outside
 report completion with single-cycle done pulses.
*/
module cmd_regs
(
	input  wire logic        clock_in,             // 25 MHz clock
	input  wire logic        srst_in,              // sync reset, active high
	input  wire logic        frame_valid_in,       // frame strobe, one cycle
	input  wire logic [15:0] frame_sel_in,         // selector of frame
	input  wire logic [15:0] frame_arg_in,         // argument of frame
	input  wire logic        frame_crc_ok_in,      // checksum passed
	input  wire logic        cmd_busy_in,          // another command executing
	input  wire logic        over_temp_in,         // temperature too high
	input  wire logic        chain_end_in,         // last asic ended readout
	input  wire logic        mem_sat_in,           // analog memory saturated
	input  wire logic        readout_start_in,     // readout start command
	input  wire logic        acq_start_in,         // acquisition start command
	input  wire logic [6:0]  info_done_in,         // info word sent, per bit
	input  wire logic        upload_done_in,       // config upload finished
	input  wire logic        first_word_in,        // first data word strobe
	input  wire logic [7:0]  first_hdr_in,         // header of first word
	input  wire logic        download_done_in,     // firmware download finished
	input  wire logic        download_crc_ok_in,   // download checksum passed
	input  wire logic        prewarn_done_in,      // active mode entered
	input  wire logic        dump_done_in,         // register dump sent
	input  wire logic        fast_done_in,         // fast command generated
	input  wire logic        beam_window_in,       // external beam window
	input  wire logic        trigger_in,           // trigger pulse
	input  wire logic        hw_busy_in,           // hardware busy output
	input  wire logic        rd_in,                // read of selected register
	input  wire logic [15:0] rd_sel_in,            // read selector
	output logic      [15:0] rd_data_out,          // read data, registered
	output logic      [15:0] primary_status_word_out,          // first status word
	output logic      [15:0] secondary_status_word_out,          // second status word
	output logic      [6:0]  info_req_out,         // info request bits
	output logic      [15:0] info_word_out,        // selected info word
	output logic             upload_req_out,       // config upload request
	output logic             download_req_out,     // firmware download request
	output logic             src_board_out,        // board-to-board source
	output logic             selector_rst_out,     // selection logic reset
	output logic             prewarn_req_out,      // go to active mode
	output logic             dump_req_out,         // dump all registers
	output logic             fast_req_out,         // generate fast command
	output logic             meas_run_out,         // measurement running
	output logic             sc_hit_out,           // selector in partition range
	output logic      [2:0]  sc_part_out,          // partition 0..3, set bit 0
	output logic             cmd_ok_out            // frame accepted for execute
);
	// ============================================================
	// selector decode
	function automatic logic known_cmd(input logic [15:0] s);
		known_cmd = (s <= cmd_regs_pkg::CMD_LAST) && !s[0];
	endfunction

	logic        take;
	logic        known;
	logic [15:0] st1_q;
	logic [15:0] st2_q;
	logic [6:0]  info_q;
	logic        upl_q;
	logic [7:0]  hdr_q;
	logic        dl_q;
	logic        dl_crc_q;
	logic        src_q;
	logic        selrst_q;
	logic [2:0]  selcnt_q;
	logic        pre_q;
	logic        dump_q;
	logic        fast_q;
	logic        done_q;
	logic [4:0]  hit_q;
	cmd_regs_pkg::arm_state_t arm_q;

	assign known = known_cmd(frame_sel_in)
		|| (frame_sel_in >= cmd_regs_pkg::SC_FIRST && frame_sel_in <= cmd_regs_pkg::SC_LAST);
	assign take = frame_valid_in && frame_crc_ok_in && known && !cmd_busy_in;
	assign cmd_ok_out = take;
	assign sc_hit_out = frame_valid_in && frame_sel_in >= cmd_regs_pkg::SC_FIRST
		&& frame_sel_in <= cmd_regs_pkg::SC_LAST;
	// 0x1000 -> 0, 0x2000 -> 1: odd nibble is default set
	assign sc_part_out = 3'(frame_sel_in[15:12] - 4'h1);

	// ============================================================
	// first status word, read only
	always_ff @(posedge clock_in)
	begin
		if (srst_in)
			st1_q <= cmd_regs_pkg::ZERO16;
		else
		begin
			st1_q[cmd_regs_pkg::ST_TEMP] <= over_temp_in;
			if (frame_valid_in)
			begin
				st1_q[cmd_regs_pkg::ST_CRC] <= !frame_crc_ok_in;
				st1_q[cmd_regs_pkg::ST_UNK] <= frame_crc_ok_in && !known;
				st1_q[cmd_regs_pkg::ST_REJ] <= frame_crc_ok_in && known && cmd_busy_in;
			end
		end
	end

	// ============================================================
	// second status word; set wins over clear
	always_ff @(posedge clock_in)
	begin
		if (srst_in)
			st2_q <= cmd_regs_pkg::ZERO16;
		else
		begin
			if (chain_end_in)
				st2_q[cmd_regs_pkg::SEC_END] <= 1'b1;
			else if (readout_start_in)
				st2_q[cmd_regs_pkg::SEC_END] <= 1'b0;
			if (mem_sat_in)
				st2_q[cmd_regs_pkg::SEC_SAT] <= 1'b1;
			else if (acq_start_in)
				st2_q[cmd_regs_pkg::SEC_SAT] <= 1'b0;
		end
	end

	// ============================================================
	// self-clearing request bits: a new set wins over the done pulse
	// so a request landing on the completion cycle is never lost
	function automatic logic req_next(input logic cur, input logic set, input logic done);
		req_next = set | (cur & !done);
	endfunction

	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			info_q <= 7'h00;
			upl_q <= 1'b0;
			dl_q <= 1'b0;
			pre_q <= 1'b0;
			dump_q <= 1'b0;
			fast_q <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < cmd_regs_pkg::INFO_BITS; i++)
				info_q[i] <= req_next(info_q[i],
					take && frame_sel_in == cmd_regs_pkg::OFS_INFO && frame_arg_in[i],
					info_done_in[i]);
			upl_q <= req_next(upl_q, take && frame_sel_in == cmd_regs_pkg::OFS_READBACK
				&& frame_arg_in[0], upload_done_in);
			dl_q <= req_next(dl_q, take && frame_sel_in == cmd_regs_pkg::OFS_FW_DL
				&& frame_arg_in[0], download_done_in);
			pre_q <= req_next(pre_q, take && frame_sel_in == cmd_regs_pkg::OFS_PREWARN
				&& frame_arg_in[0], prewarn_done_in);
			dump_q <= req_next(dump_q, take && frame_sel_in == cmd_regs_pkg::OFS_DUMP
				&& frame_arg_in[0], dump_done_in);
			fast_q <= req_next(fast_q, take && frame_sel_in == cmd_regs_pkg::OFS_FAST
				&& frame_arg_in[0], fast_done_in);
		end
	end

	// ============================================================
	// header capture and download checksum
	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			hdr_q <= 8'h00;
			dl_crc_q <= 1'b0;
		end
		else
		begin
			if (first_word_in)
				hdr_q <= first_hdr_in;
			if (download_done_in)
				dl_crc_q <= download_crc_ok_in;
		end
	end

	// ============================================================
	// input selection and its timed reset
	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			src_q <= 1'b0;
			selrst_q <= 1'b0;
			selcnt_q <= 3'h0;
		end
		else if (take && frame_sel_in == cmd_regs_pkg::OFS_SRC_SEL && !selrst_q)
		begin
			src_q <= frame_arg_in[0];
			selrst_q <= frame_arg_in[cmd_regs_pkg::SELRST_BIT];
			selcnt_q <= cmd_regs_pkg::SELRST_CNT;
		end
		else if (selrst_q)
		begin
			// count runs while held; bit drops after the fourth cycle
			selcnt_q <= selcnt_q - 3'h1;
			selrst_q <= selcnt_q != 3'h1;
		end
	end

	// ============================================================
	// beam measurement: arm, wait for window, count triggers
	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			arm_q <= cmd_regs_pkg::ARM_IDLE;
			done_q <= 1'b0;
			hit_q <= 5'h00;
		end
		else if (take && frame_sel_in == cmd_regs_pkg::OFS_ARM && frame_arg_in[0])
		begin
			arm_q <= cmd_regs_pkg::ARM_WAIT;
			done_q <= 1'b0;
			hit_q <= 5'h00;
		end
		else
		begin
			case (arm_q)
				cmd_regs_pkg::ARM_WAIT:
					if (beam_window_in)
						arm_q <= cmd_regs_pkg::ARM_MEAS;
				cmd_regs_pkg::ARM_MEAS:
				begin
					// saturates so an overrun stays visible
					if (trigger_in && beam_window_in && hit_q != 5'h1f)
						hit_q <= hit_q + 5'h01;
					if (!beam_window_in)
					begin
						arm_q <= cmd_regs_pkg::ARM_IDLE;
						done_q <= 1'b1;
					end
				end
				default:
					arm_q <= cmd_regs_pkg::ARM_IDLE;
			endcase
		end
	end

	// ============================================================
	// outputs and read mux
	logic [15:0] cmp_w;
	logic [15:0] info_w;
	assign cmp_w = {8'h00, hit_q, hw_busy_in, arm_q == cmd_regs_pkg::ARM_MEAS && beam_window_in, done_q};
	always_comb
	begin
		info_w = cmd_regs_pkg::ZERO16;
		if (info_q[5])
			info_w = cmd_regs_pkg::INFO_SERIAL;
		else if (info_q[4])
			info_w = cmd_regs_pkg::INFO_BOARD_REV;
		else if (info_q[3])
			info_w = cmd_regs_pkg::INFO_BOARD_NUM;
		else if (info_q[2])
			info_w = cmd_regs_pkg::INFO_PROD_DAY;
		else if (info_q[1])
			info_w = cmd_regs_pkg::INFO_FW_REV;
		else if (info_q[0])
			info_w = cmd_regs_pkg::INFO_FW_DAY;
	end

	always_ff @(posedge clock_in)
	begin
		if (srst_in)
			rd_data_out <= cmd_regs_pkg::ZERO16;
		else if (rd_in)
		begin
			case (rd_sel_in)
				cmd_regs_pkg::OFS_INFO:       rd_data_out <= {9'h000, info_q};
				cmd_regs_pkg::OFS_READBACK:   rd_data_out <= {7'h00, hdr_q, upl_q};
				cmd_regs_pkg::OFS_FW_DL:      rd_data_out <= {14'h0000, dl_crc_q, dl_q};
				cmd_regs_pkg::OFS_SRC_SEL:    rd_data_out <= {14'h0000, selrst_q, src_q};
				cmd_regs_pkg::OFS_PREWARN:    rd_data_out <= {15'h0000, pre_q};
				cmd_regs_pkg::OFS_DUMP:       rd_data_out <= {15'h0000, dump_q};
				cmd_regs_pkg::OFS_FAST:       rd_data_out <= {15'h0000, fast_q};
				cmd_regs_pkg::OFS_COMPLETION: rd_data_out <= cmp_w;
				default:                      rd_data_out <= cmd_regs_pkg::ZERO16;
			endcase
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (srst_in)
			info_word_out <= cmd_regs_pkg::ZERO16;
		else
			info_word_out <= info_w;
	end

	assign primary_status_word_out = st1_q;
	assign secondary_status_word_out = st2_q;
	assign info_req_out = info_q;
	assign upload_req_out = upl_q;
	assign download_req_out = dl_q;
	assign src_board_out = src_q;
	assign selector_rst_out = selrst_q;
	assign prewarn_req_out = pre_q;
	assign dump_req_out = dump_q;
	assign fast_req_out = fast_q;
	assign meas_run_out = arm_q == cmd_regs_pkg::ARM_MEAS;

	// ============================================================
	// checks
	temp_flag_a: assert property (@(posedge clock_in) disable iff (srst_in)
		##1 primary_status_word_out[3] == $past(over_temp_in)) else $error("temperature flag wrong");
	reject_flag_a: assert property (@(posedge clock_in) disable iff (srst_in)
		frame_valid_in && frame_crc_ok_in && known && cmd_busy_in |=> primary_status_word_out[2])
		else $error("reject flag not set");
	unknown_flag_a: assert property (@(posedge clock_in) disable iff (srst_in)
		frame_valid_in && frame_crc_ok_in && !known |=> primary_status_word_out[1] && !primary_status_word_out[2])
		else $error("unknown flag not set");
	crc_flag_a: assert property (@(posedge clock_in) disable iff (srst_in)
		frame_valid_in |=> primary_status_word_out[0] == !$past(frame_crc_ok_in)) else $error("crc flag wrong");
	chain_end_a: assert property (@(posedge clock_in) disable iff (srst_in)
		chain_end_in |=> secondary_status_word_out[1]) else $error("chain end lost");
	sat_clear_a: assert property (@(posedge clock_in) disable iff (srst_in)
		acq_start_in && !mem_sat_in |=> !secondary_status_word_out[0]) else $error("saturation not cleared");
	selrst_len_a: assert property (@(posedge clock_in) disable iff (srst_in)
		$rose(selector_rst_out) |-> selector_rst_out[*4] ##1 !selector_rst_out)
		else $error("selector reset length wrong");
	src_keep_a: assert property (@(posedge clock_in) disable iff (srst_in)
		selector_rst_out |=> $stable(src_board_out))
		else $error("source changed during selector reset");
	arm_clear_a: assert property (@(posedge clock_in) disable iff (srst_in)
		take && frame_sel_in == cmd_regs_pkg::OFS_ARM && frame_arg_in[0]
		|=> done_q == 1'b0 && hit_q == 5'h00 && !meas_run_out) else $error("arm did not clear");
	wait_window_a: assert property (@(posedge clock_in) disable iff (srst_in)
		arm_q == cmd_regs_pkg::ARM_WAIT && !beam_window_in && !take |=> !meas_run_out)
		else $error("started without window");
	hit_count_count_a: assert property (@(posedge clock_in) disable iff (srst_in)
		meas_run_out && trigger_in && beam_window_in && !take && hit_q != 5'h1f
		|=> hit_q == $past(hit_q) + 5'h01) else $error("trigger not counted");
	upload_done_a: assert property (@(posedge clock_in) disable iff (srst_in)
		upload_done_in && !(take && frame_sel_in == cmd_regs_pkg::OFS_READBACK && frame_arg_in[0])
		|=> !upload_req_out) else $error("upload bit not cleared");
	req_set_a: assert property (@(posedge clock_in) disable iff (srst_in)
		take && frame_sel_in == cmd_regs_pkg::OFS_DUMP && frame_arg_in[0] |=> dump_req_out)
		else $error("dump request not set");
	dl_crc_a: assert property (@(posedge clock_in) disable iff (srst_in)
		download_done_in |=> dl_crc_q == $past(download_crc_ok_in))
		else $error("download checksum bit wrong");
	hdr_capture_a: assert property (@(posedge clock_in) disable iff (srst_in)
		first_word_in |=> hdr_q == $past(first_hdr_in))
		else $error("header not captured");
endmodule

// ---- tb/concentrator_model.sv ----
/*
 upstream concentrator model: issues one block-transfer frame per call of send.
 assumes the caller runs on clock_in and waits for send to return before the next frame.
*/
module concentrator_model
(
	input  wire logic        clock_in,         // bench clock
	input  wire logic        cmd_ok_in,        // frame accepted for execute
	output logic             frame_valid_out,  // frame strobe
	output logic      [15:0] frame_sel_out,    // selector
	output logic      [15:0] frame_arg_out,    // argument
	output logic             frame_crc_ok_out  // checksum verdict
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		frame_valid_out = 1'b0;
		frame_sel_out = 16'h0000;
		frame_arg_out = 16'h0000;
		frame_crc_ok_out = 1'b0;
	end

	// ============================================================
	// frame issue
	// lines are not held after the strobe: show the inverse so stale data cannot pass
	task automatic send(input logic [15:0] sel, input logic [15:0] arg, input logic crc, output logic ok);
		@(posedge clock_in);
		frame_valid_out <= 1'b1;
		frame_sel_out <= sel;
		frame_arg_out <= arg;
		frame_crc_ok_out <= crc;
		@(posedge clock_in);
		ok = cmd_ok_in;
		frame_valid_out <= 1'b0;
		frame_sel_out <= ~sel;
		frame_arg_out <= ~arg;
		frame_crc_ok_out <= ~crc;
		@(negedge clock_in);
	endtask
endmodule

// ---- tb/testbench.sv ----
/*
 self-checking bench of the command register bank, expectations from a small model.
 assumes the concentrator model in its own file; single 25 MHz clock.
*/
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clock_in, srst_in, frame_valid_in, frame_crc_ok_in, cmd_busy_in, over_temp_in;
	logic        beam_window_in, hw_busy_in, rd_in, download_crc_ok_in, ok;
	logic        chain_end_in, mem_sat_in, readout_start_in, acq_start_in, first_word_in, trigger_in;
	logic        upload_done_in, download_done_in, prewarn_done_in, dump_done_in, fast_done_in;
	logic        upload_req_out, download_req_out, src_board_out, selector_rst_out, prewarn_req_out;
	logic        dump_req_out, fast_req_out, meas_run_out, cmd_ok_out, sc_hit_out, hs;
	logic [2:0]  sc_part_out, ps;
	logic [15:0] frame_sel_in, frame_arg_in, rd_sel_in, rd_data_out, primary_status_word_out, secondary_status_word_out, info_word_out, a;
	logic [6:0]  info_done_in, info_req_out;
	logic [7:0]  first_hdr_in;
	logic [10:0] pv;
	logic [4:0]  req;
	int          seed, n, n_tests, n_mismatch;
	logic [15:0] sels [8] = '{16'h0000, 16'h0090, 16'h1000, 16'h8fff, 16'h0015, 16'h0092, 16'h0800, 16'h9000};
	logic [15:0] reqsel [5] = '{16'h0016, 16'h0018, 16'h001c, 16'h001e, 16'h0020};

	assign {chain_end_in, mem_sat_in, readout_start_in, acq_start_in, first_word_in, trigger_in} = pv[10:5];
	assign {upload_done_in, download_done_in, prewarn_done_in, dump_done_in, fast_done_in} = pv[4:0];
	assign req = {upload_req_out, download_req_out, prewarn_req_out, dump_req_out, fast_req_out};

	cmd_regs i_cmd_regs
	(
		.clock_in(clock_in), .srst_in(srst_in), .frame_valid_in(frame_valid_in), .frame_sel_in(frame_sel_in),
		.frame_arg_in(frame_arg_in), .frame_crc_ok_in(frame_crc_ok_in), .cmd_busy_in(cmd_busy_in),
		.over_temp_in(over_temp_in), .chain_end_in(chain_end_in), .mem_sat_in(mem_sat_in),
		.readout_start_in(readout_start_in), .acq_start_in(acq_start_in), .info_done_in(info_done_in),
		.upload_done_in(upload_done_in), .first_word_in(first_word_in), .first_hdr_in(first_hdr_in),
		.download_done_in(download_done_in), .download_crc_ok_in(download_crc_ok_in),
		.prewarn_done_in(prewarn_done_in), .dump_done_in(dump_done_in), .fast_done_in(fast_done_in),
		.beam_window_in(beam_window_in), .trigger_in(trigger_in), .hw_busy_in(hw_busy_in), .rd_in(rd_in),
		.rd_sel_in(rd_sel_in), .rd_data_out(rd_data_out), .primary_status_word_out(primary_status_word_out),
		.secondary_status_word_out(secondary_status_word_out), .info_req_out(info_req_out), .info_word_out(info_word_out),
		.upload_req_out(upload_req_out), .download_req_out(download_req_out), .src_board_out(src_board_out),
		.selector_rst_out(selector_rst_out), .prewarn_req_out(prewarn_req_out), .dump_req_out(dump_req_out),
		.fast_req_out(fast_req_out), .meas_run_out(meas_run_out), .sc_hit_out(sc_hit_out),
		.sc_part_out(sc_part_out),
		.cmd_ok_out(cmd_ok_out)
	);

	concentrator_model i_concentrator_model
	(
		.clock_in(clock_in), .cmd_ok_in(cmd_ok_out), .frame_valid_out(frame_valid_in),
		.frame_sel_out(frame_sel_in), .frame_arg_out(frame_arg_in), .frame_crc_ok_out(frame_crc_ok_in)
	);

	initial
	begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end

	// partition decode only means something while a frame stands
	always @(negedge clock_in)
		if (frame_valid_in)
			{hs, ps} <= {sc_hit_out, sc_part_out};

	// ============================================================
	// helpers
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int c);
		repeat (c) @(negedge clock_in);
	endtask

	task automatic pulse(input int b);
		@(posedge clock_in);
		pv <= 11'(1 << b);
		@(posedge clock_in);
		pv <= 11'h000;
		@(negedge clock_in);
	endtask

	task automatic rdchk(input logic [15:0] sel, input logic [15:0] exp);
		@(posedge clock_in);
		rd_in <= 1'b1;
		rd_sel_in <= sel;
		@(posedge clock_in);
		rd_in <= 1'b0;
		@(negedge clock_in);
		chk(rd_data_out, exp);
	endtask

	// highest pending request among bits 5..0 names the word shown
	function automatic logic [15:0] info_exp(input logic [15:0] r);
		logic [15:0] w;
		logic [15:0] words [6];
		words = '{cmd_regs_pkg::INFO_FW_DAY, cmd_regs_pkg::INFO_FW_REV, cmd_regs_pkg::INFO_PROD_DAY,
			cmd_regs_pkg::INFO_BOARD_NUM, cmd_regs_pkg::INFO_BOARD_REV, cmd_regs_pkg::INFO_SERIAL};
		w = 16'h0000;
		for (int i = 0; i < 6; i++)
			if (r[i])
				w = words[i];
		return w;
	endfunction

	task automatic final_report();
		$display("checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ============================================================
	// watchdog: the sequence needs well under a thousand cycles
	initial
	begin
		#400000;
		n_mismatch++;
		final_report();
	end

	// ============================================================
	// main sequence
	initial
	begin
		seed = 14;
		n_tests = 0;
		n_mismatch = 0;
		srst_in = 1'b1;
		{cmd_busy_in, over_temp_in, beam_window_in, hw_busy_in, rd_in, download_crc_ok_in} = '0;
		{pv, info_done_in, first_hdr_in, rd_sel_in} = '0;
		repeat (12) @(posedge clock_in);
		srst_in <= 1'b0;
		tick(1);
		chk(primary_status_word_out, 16'h0000);
		chk(secondary_status_word_out, 16'h0000);
		for (int i = 0; i < 8; i++)
		begin
			i_concentrator_model.send(sels[i], 16'h0000, 1'b1, ok);
			chk(16'(ok), 16'(i < 4));
			chk(primary_status_word_out, (i < 4) ? 16'h0000 : 16'h0002);
			chk(16'({hs, hs ? ps : 3'h0}), (i == 2 || i == 3) ? 16'h0008 | ((sels[i] >> 12) - 16'h0001) : 16'h0000);
		end
		i_concentrator_model.send(16'h0014, 16'h0020, 1'b0, ok);
		chk(primary_status_word_out, 16'h0001);
		chk(16'(info_req_out), 16'h0000);
		@(posedge clock_in);
		cmd_busy_in <= 1'b1;
		i_concentrator_model.send(16'h0014, 16'h0020, 1'b1, ok);
		chk(primary_status_word_out, 16'h0004);
		chk(16'(info_req_out), 16'h0000);
		@(posedge clock_in);
		cmd_busy_in <= 1'b0;
		a = (16'($random(seed)) & 16'h007f) | 16'h0001;
		i_concentrator_model.send(16'h0014, a, 1'b1, ok);
		tick(1);
		chk(primary_status_word_out, 16'h0000);
		chk(16'(info_req_out), a);
		chk(info_word_out, info_exp(a));
		@(posedge clock_in);
		info_done_in <= a[6:0];
		@(posedge clock_in);
		info_done_in <= 7'h00;
		tick(1);
		chk(16'(info_req_out), 16'h0000);
		i_concentrator_model.send(16'h001a, 16'h0002, 1'b1, ok);
		for (int i = 0; i < 5; i++)
		begin
			chk(16'(selector_rst_out), 16'(i < 4));
			tick(1);
		end
		i_concentrator_model.send(16'h001a, 16'hfffd, 1'b1, ok);
		chk(16'(src_board_out), 16'h0001);
		rdchk(16'h001a, 16'h0001);
		i_concentrator_model.send(16'h001a, 16'h0000, 1'b1, ok);
		chk(16'(src_board_out), 16'h0000);
		rdchk(16'h0092, 16'h0000);
		@(posedge clock_in);
		download_crc_ok_in <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			i_concentrator_model.send(reqsel[i], 16'h0001, 1'b1, ok);
			chk(16'(req), 16'(5'h10 >> i));
			pulse(4 - i);
			chk(16'(req), 16'h0000);
		end
		rdchk(16'h0018, 16'h0002);
		@(posedge clock_in);
		download_crc_ok_in <= 1'b0;
		i_concentrator_model.send(16'h0018, 16'h0001, 1'b1, ok);
		pulse(3);
		rdchk(16'h0018, 16'h0000);
		@(posedge clock_in);
		first_hdr_in <= 8'($random(seed));
		pulse(6);
		rdchk(16'h0016, {7'h00, first_hdr_in, 1'b0});
		@(posedge clock_in);
		over_temp_in <= 1'b1;
		tick(2);
		chk(16'(primary_status_word_out[3]), 16'h0001);
		@(posedge clock_in);
		over_temp_in <= 1'b0;
		tick(2);
		chk(16'(primary_status_word_out[3]), 16'h0000);
		pulse(10);
		chk(secondary_status_word_out, 16'h0002);
		pulse(9);
		chk(secondary_status_word_out, 16'h0003);
		pulse(8);
		chk(secondary_status_word_out, 16'h0001);
		pulse(7);
		chk(secondary_status_word_out, 16'h0000);
		i_concentrator_model.send(16'h0086, 16'h0001, 1'b1, ok);
		tick(6);
		chk(16'(meas_run_out), 16'h0000);
		@(posedge clock_in);
		beam_window_in <= 1'b1;
		tick(3);
		chk(16'(meas_run_out), 16'h0001);
		n = $unsigned($random(seed)) % 21;
		repeat (n) pulse(5);
		@(posedge clock_in);
		beam_window_in <= 1'b0;
		hw_busy_in <= 1'b1;
		tick(3);
		chk(16'(meas_run_out), 16'h0000);
		rdchk(16'h0084, {8'h00, 5'(n), 3'b101});
		@(posedge clock_in);
		hw_busy_in <= 1'b0;
		i_concentrator_model.send(16'h0086, 16'h0001, 1'b1, ok);
		rdchk(16'h0084, 16'h0000);
		final_report();
	end
endmodule
